// ### inc/dpg_defs.svh
// constants for the dual pulse generator
// assumes a single machine clock and a synchronous reset
`ifndef DPG_DEFS_SVH
`define DPG_DEFS_SVH
`define DPG_W          8
`define DPG_ZERO8      8'h00
`define DPG_ONES8      8'hff
`define DPG_ONE8       8'h01
`define DPG_DIV_W      4
`define DPG_DIV_ZERO   4'h0
`define DPG_DIV_ONE    4'h1
`define DPG_TB_W       9
`define DPG_TB_ZERO    9'h000
`define DPG_TB_ONE     9'h001
`define DPG_TB_MAX     9'h1ff
`define DPG_SEL_W      3
`define DPG_MODE_W     2
`endif

// ### inc/dpg_pkg.sv
// types for the dual pulse generator
// assumes dpg_defs.svh is on the include path
`include "dpg_defs.svh"
package dpg_pkg;
  typedef enum logic [`DPG_MODE_W-1:0] {
    DPG_MODE_INDEP = 2'b00,
    DPG_MODE_WIDE  = 2'b01,
    DPG_MODE_CHAIN = 2'b10
  } dpg_mode_e;
  typedef enum logic [`DPG_SEL_W-1:0] {
    DPG_CLK_DIV1  = 3'b000,
    DPG_CLK_DIV2  = 3'b001,
    DPG_CLK_DIV4  = 3'b010,
    DPG_CLK_DIV8  = 3'b011,
    DPG_CLK_DIV16 = 3'b100,
    DPG_CLK_TB512 = 3'b101
  } dpg_clksel_e;
endpackage : dpg_pkg

// ### hw/dpg_clock_select.sv
// count clock tick generator: machine clock divisions and timebase tick
// assumes timebaseTick is already on the machine clock, one cycle wide
`include "dpg_defs.svh"
module dpg_clock_select
  import dpg_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire dpg_pkg::dpg_clksel_e clockSel,
  input  wire logic                 timebaseTick,
  output logic                      countTick
);
  typedef struct packed {
    logic [`DPG_DIV_W-1:0] div;
    logic [`DPG_TB_W-1:0]  tb;
    logic                  tick;
  } dpg_cs_s;
  dpg_cs_s st_reg;
  dpg_cs_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.div = st_reg.div + `DPG_DIV_ONE;
    if (timebaseTick) begin
      st_next.tb = st_reg.tb + `DPG_TB_ONE;
    end
    unique case (clockSel)
      DPG_CLK_DIV1:  st_next.tick = 1'b1;
      DPG_CLK_DIV2:  st_next.tick = &st_reg.div[0:0];
      DPG_CLK_DIV4:  st_next.tick = &st_reg.div[1:0];
      DPG_CLK_DIV8:  st_next.tick = &st_reg.div[2:0];
      DPG_CLK_DIV16: st_next.tick = &st_reg.div[3:0];
      DPG_CLK_TB512: st_next.tick = timebaseTick
                                    && (st_reg.tb == `DPG_TB_MAX);
      default:       st_next.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '{div: `DPG_DIV_ZERO, tb: `DPG_TB_ZERO, tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign countTick = st_reg.tick;
endmodule : dpg_clock_select

// ### hw/dpg_pulse_gen.sv
// two-channel pulse generator with independent, 16-bit and chained modes
// assumes control ports are static-ish software bits on the machine clock
`include "dpg_defs.svh"
module dpg_pulse_gen
  import dpg_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire dpg_pkg::dpg_mode_e   mode,
  input  wire dpg_pkg::dpg_clksel_e chanAClockSel,
  input  wire dpg_pkg::dpg_clksel_e chanBClockSel,
  input  wire logic                 timebaseTick,
  input  wire logic                 chanAEnable,
  input  wire logic                 chanBEnable,
  input  wire logic                 chanAIrqEnable,
  input  wire logic                 chanBIrqEnable,
  input  wire logic                 chanAFlagClear,
  input  wire logic                 chanBFlagClear,
  input  wire logic                 chanAHighWrite,
  input  wire logic                 chanALowWrite,
  input  wire logic                 chanBHighWrite,
  input  wire logic                 chanBLowWrite,
  input  wire logic [`DPG_W-1:0]    writeData,
  output logic                      chanAOutFirst,
  output logic                      chanAOutSecond,
  output logic                      chanBOutFirst,
  output logic                      chanBOutSecond,
  output logic                      chanAUnderflowFlag,
  output logic                      chanBUnderflowFlag,
  output logic                      chanAIrq,
  output logic                      chanBIrq
);
  typedef struct packed {
    logic [`DPG_W-1:0] aHigh;
    logic [`DPG_W-1:0] aLow;
    logic [`DPG_W-1:0] bHigh;
    logic [`DPG_W-1:0] bLow;
    logic [`DPG_W-1:0] aHighStage;
    logic [`DPG_W-1:0] bHighStage;
    logic              aStaged;
    logic              bStaged;
    logic [`DPG_W-1:0] aCount;
    logic [`DPG_W-1:0] bCount;
    logic              aRun;
    logic              bRun;
    logic              aLevel;
    logic              bLevel;
    logic              aFlag;
    logic              bFlag;
    logic              aIrq;
    logic              bIrq;
    logic              pinA1;
    logic              pinA2;
    logic              pinB1;
    logic              pinB2;
  } dpg_st_s;

  dpg_st_s st_reg;
  dpg_st_s st_next;
  logic    tickA;
  logic    tickB;
  logic    uflA;
  logic    uflB;
  logic    wideUfl;
  logic    tickBUse;

  dpg_clock_select clkSelA (
    .clock        (clock),
    .rst          (rst),
    .clockSel     (chanAClockSel),
    .timebaseTick (timebaseTick),
    .countTick    (tickA)
  );
  dpg_clock_select clkSelB (
    .clock        (clock),
    .rst          (rst),
    .clockSel     (chanBClockSel),
    .timebaseTick (timebaseTick),
    .countTick    (tickB)
  );

  function automatic logic [`DPG_W-1:0] pickReload(
    input logic              level,
    input logic [`DPG_W-1:0] high,
    input logic [`DPG_W-1:0] low
  );
    pickReload = level ? high : low;
  endfunction : pickReload

  always_comb begin
    st_next = st_reg;
    // high write staged until low write
    if (chanAHighWrite) begin
      st_next.aHighStage = writeData;
      st_next.aStaged    = 1'b1;
    end
    if (chanALowWrite) begin
      st_next.aLow = writeData;
      if (st_reg.aStaged) begin
        st_next.aHigh   = st_reg.aHighStage;
        st_next.aStaged = 1'b0;
      end
    end
    if (chanBHighWrite) begin
      st_next.bHighStage = writeData;
      st_next.bStaged    = 1'b1;
    end
    if (chanBLowWrite) begin
      st_next.bLow = writeData;
      if (st_reg.bStaged) begin
        st_next.bHigh   = st_reg.bHighStage;
        st_next.bStaged = 1'b0;
      end
    end

    uflA    = st_reg.aRun && tickA && (st_reg.aCount == `DPG_ZERO8);
    wideUfl = 1'b0;
    uflB    = 1'b0;
    tickBUse = tickB;
    unique case (mode)
      // channel a underflow clocks channel b
      DPG_MODE_CHAIN: tickBUse = uflA;
      // counters linked, a is low byte
      DPG_MODE_WIDE:  tickBUse = st_reg.aRun && tickA
                                 && (st_reg.aCount == `DPG_ZERO8);
      DPG_MODE_INDEP: tickBUse = tickB;
      default:        tickBUse = 1'b0;
    endcase
    uflB = st_reg.bRun && tickBUse && (st_reg.bCount == `DPG_ZERO8);
    if (mode == DPG_MODE_WIDE) begin
      // 16-bit phase from 1 to 65536 counts
      wideUfl = uflB;
      uflA    = 1'b0;
    end

    // channel a counter
    if (!chanAEnable) begin
      st_next.aRun   = 1'b0;
      st_next.aLevel = 1'b0;
    end else if (!st_reg.aRun) begin
      st_next.aRun   = 1'b1;
      st_next.aCount = pickReload(1'b0, st_reg.aHigh, st_reg.aLow);
    end else if (mode == DPG_MODE_WIDE) begin
      if (wideUfl) begin
        st_next.aLevel = !st_reg.aLevel;
        st_next.aCount = pickReload(!st_reg.aLevel, st_reg.aHigh,
                                    st_reg.aLow);
      end else if (tickA) begin
        st_next.aCount = st_reg.aCount - `DPG_ONE8;
      end
    end else if (uflA) begin
      st_next.aLevel = !st_reg.aLevel;
      st_next.aCount = pickReload(!st_reg.aLevel, st_reg.aHigh,
                                  st_reg.aLow);
    end else if (tickA) begin
      st_next.aCount = st_reg.aCount - `DPG_ONE8;
    end

    // channel b counter
    if (!chanBEnable) begin
      st_next.bRun   = 1'b0;
      st_next.bLevel = 1'b0;
    end else if (!st_reg.bRun) begin
      st_next.bRun   = 1'b1;
      st_next.bCount = pickReload(1'b0, st_reg.bHigh, st_reg.bLow);
    end else if (uflB) begin
      st_next.bLevel = !st_reg.bLevel;
      st_next.bCount = pickReload(!st_reg.bLevel, st_reg.bHigh,
                                  st_reg.bLow);
    end else if (tickBUse) begin
      st_next.bCount = st_reg.bCount - `DPG_ONE8;
    end

    if (chanAFlagClear) begin
      st_next.aFlag = 1'b0;
    end
    if (chanBFlagClear) begin
      st_next.bFlag = 1'b0;
    end
    if (uflA) begin
      st_next.aFlag = 1'b1;
    end
    if (uflB) begin
      st_next.bFlag = 1'b1;
    end
    st_next.aIrq = st_next.aFlag && chanAIrqEnable;
    st_next.bIrq = st_next.bFlag && chanBIrqEnable;

    st_next.pinA1 = st_next.aLevel;
    st_next.pinA2 = st_next.aLevel;
    st_next.pinB1 = st_next.bLevel;
    st_next.pinB2 = st_next.bLevel;
    if (mode == DPG_MODE_WIDE) begin
      st_next.pinA1 = st_next.aLevel;
      st_next.pinA2 = st_next.aLevel;
      st_next.pinB1 = st_next.aLevel;
      st_next.pinB2 = st_next.aLevel;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign chanAOutFirst      = st_reg.pinA1;
  assign chanAOutSecond     = st_reg.pinA2;
  assign chanBOutFirst      = st_reg.pinB1;
  assign chanBOutSecond     = st_reg.pinB2;
  assign chanAUnderflowFlag = st_reg.aFlag;
  assign chanBUnderflowFlag = st_reg.bFlag;
  assign chanAIrq           = st_reg.aIrq;
  assign chanBIrq           = st_reg.bIrq;
endmodule : dpg_pulse_gen

// ### tb/dpg_pulse_gen_properties.sv
// port checker for the dual pulse generator
// assumes mode and clock selects change only while rst is high
module dpg_pulse_props
  import dpg_pkg::*;
(
  input wire logic               clock,
  input wire logic               rst,
  input wire dpg_pkg::dpg_mode_e mode,
  input wire logic               chanAEnable,
  input wire logic               chanAIrqEnable,
  input wire logic               chanAFlagClear,
  input wire logic               chanAOutFirst,
  input wire logic               chanAOutSecond,
  input wire logic               chanBOutFirst,
  input wire logic               chanBOutSecond,
  input wire logic               chanAUnderflowFlag,
  input wire logic               chanAIrq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  reset_quiet_a :
    assert property (disable iff (1'b0) rst |=> !chanAOutFirst
      && !chanBOutFirst && !chanAUnderflowFlag && !chanAIrq)
    else $error("outputs set after reset");
  pin_pairs_a :
    assert property (chanAOutFirst == chanAOutSecond
      && chanBOutFirst == chanBOutSecond) else $error("pin pair split");
  wide_pins_a :
    assert property (mode == DPG_MODE_WIDE
      |-> chanBOutFirst == chanAOutFirst) else $error("wide pins split");
  flag_toggle_a :
    assert property ($rose(chanAUnderflowFlag) |-> $changed(chanAOutFirst))
    else $error("flag without toggle");
  irq_raise_a :
    assert property ($rose(chanAUnderflowFlag) && $past(chanAIrqEnable)
      |-> chanAIrq) else $error("irq missing");
  irq_cause_a :
    assert property (chanAIrq |-> chanAUnderflowFlag)
    else $error("irq without flag");
  flag_hold_a :
    assert property ($fell(chanAUnderflowFlag)
      |-> $past(chanAFlagClear)) else $error("flag dropped alone");
  flag_clear_a :
    assert property (chanAFlagClear
      |=> !chanAUnderflowFlag || $changed(chanAOutFirst))
    else $error("flag kept");
  stop_low_a :
    assert property (mode == DPG_MODE_INDEP && !chanAEnable
      && !$past(chanAEnable) && !$past(chanAEnable, 2) |-> !chanAOutFirst)
    else $error("stopped pin high");
endmodule : dpg_pulse_props

bind dpg_pulse_gen dpg_pulse_props dpg_pulse_props_i (
  .clock(clock), .rst(rst), .mode(mode), .chanAEnable(chanAEnable),
  .chanAIrqEnable(chanAIrqEnable), .chanAFlagClear(chanAFlagClear),
  .chanAOutFirst(chanAOutFirst), .chanAOutSecond(chanAOutSecond),
  .chanBOutFirst(chanBOutFirst), .chanBOutSecond(chanBOutSecond),
  .chanAUnderflowFlag(chanAUnderflowFlag), .chanAIrq(chanAIrq));

// ### tb/dpg_pin_watch.sv
// far-side receiver timing the phases of one pulse pin
// assumes the pin is sampled on the machine clock
module dpg_pin_watch
(
  input wire logic clock,
  input wire logic pin,
  output int       highLen = 0,
  output int       lowLen = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  int   run = 0;
  logic last = 1'b0;
  always @(posedge clock) begin
    run <= (pin === last) ? run + 1 : 1;
    if (pin !== last && last) highLen <= run;
    if (pin !== last && !last) lowLen <= run;
    last <= pin;
  end
endmodule : dpg_pin_watch

// ### tb/dpg_pulse_gen_tb_top.sv
// testbench: strobed reload writes, phase widths timed by pin watchers
// assumes 8 ns clock, inputs driven 1 ns after each rising edge
module dpg_pulse_gen_tb_top
  import dpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  dpg_mode_e   mode = DPG_MODE_INDEP;
  dpg_clksel_e selA = DPG_CLK_DIV1;
  dpg_clksel_e selB = DPG_CLK_DIV1;
  logic        tbTick = 1'b0;
  logic [1:0]  en = 2'b00;
  logic [1:0]  irqEn = 2'b01;
  logic [1:0]  clr = 2'b00;
  logic [3:0]  wrStb = 4'h0;
  logic [7:0]  wrData = 8'h00;
  logic        aF, aS, bF, bS, aFlag, bFlag, aIrq, bIrq;
  int          aHi, aLo, bHi, bLo;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  dpg_pulse_gen dpg_pulse_gen_i (.clock(clock), .rst(rst), .mode(mode),
    .chanAClockSel(selA), .chanBClockSel(selB), .timebaseTick(tbTick),
    .chanAEnable(en[0]), .chanBEnable(en[1]), .chanAIrqEnable(irqEn[0]),
    .chanBIrqEnable(irqEn[1]), .chanAFlagClear(clr[0]),
    .chanBFlagClear(clr[1]), .chanAHighWrite(wrStb[0]),
    .chanALowWrite(wrStb[1]), .chanBHighWrite(wrStb[2]),
    .chanBLowWrite(wrStb[3]), .writeData(wrData), .chanAOutFirst(aF),
    .chanAOutSecond(aS), .chanBOutFirst(bF), .chanBOutSecond(bS),
    .chanAUnderflowFlag(aFlag), .chanBUnderflowFlag(bFlag),
    .chanAIrq(aIrq), .chanBIrq(bIrq));
  dpg_pin_watch watchA (.clock(clock), .pin(aF), .highLen(aHi),
    .lowLen(aLo));
  dpg_pin_watch watchB (.clock(clock), .pin(bF), .highLen(bHi),
    .lowLen(bLo));
  initial begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    tbTick <= #1 ~tbTick;
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input int k, input logic [7:0] d);
    wrData = d;
    wrStb = 4'h1 << k;
    cyc(1);
    wrStb = 4'h0;
    cyc(1);
  endtask : wr
  // bytes of v: chan a high, a low, b high, b low from the bottom
  task automatic start(input dpg_mode_e m, input dpg_clksel_e s,
                       input dpg_clksel_e t, input logic [31:0] v);
    rst = 1'b1;
    en = 2'b00;
    mode = m;
    selA = s;
    selB = t;
    cyc(6);
    rst = 1'b0;
    cyc(1);
    for (int i = 0; i < 4; i++) wr(i, v[8*i +: 8]);
    en = 2'b11;
  endtask : start
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      failures++;
      $display("unexpected at %0t: got %0d want %0d", $time, got, want);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    start(DPG_MODE_INDEP, DPG_CLK_DIV1, DPG_CLK_DIV2, 32'h04010203);
    chk({aF, bF, aFlag, bFlag, aIrq, bIrq}, 0);
    cyc(60);
    chk(aHi, 4);
    chk(aLo, 3);
    chk(bHi, 4);
    chk(bLo, 10);
    chk({aFlag, bFlag, aIrq, bIrq}, 4'he);
    wr(0, 8'h07);
    cyc(40);
    chk(aHi, 4);
    wr(1, 8'h02);
    cyc(40);
    chk(aHi, 8);
    en = 2'b10;
    cyc(3);
    clr = 2'b11;
    cyc(1);
    clr = 2'b00;
    cyc(1);
    chk({aF, aS, aFlag, aIrq}, 0);
    for (int s = 0; s < 5; s++) begin
      start(DPG_MODE_INDEP, dpg_clksel_e'(s), dpg_clksel_e'(s), 0);
      cyc(100);
      chk(aHi, 1 << s);
      chk(bLo, 1 << s);
    end
    start(DPG_MODE_INDEP, DPG_CLK_TB512, DPG_CLK_TB512, 0);
    cyc(2300);
    chk(aHi, 1024);
    start(DPG_MODE_WIDE, DPG_CLK_DIV1, DPG_CLK_DIV1, 32'h00010302);
    cyc(600);
    chk(bHi, 259);
    chk(aLo, 4);
    chk({aFlag, bFlag}, 2'b01);
    start(DPG_MODE_CHAIN, DPG_CLK_DIV1, DPG_CLK_DIV16, 32'h01020101);
    cyc(100);
    chk(aHi, 2);
    chk(bHi, 6);
    chk(bLo, 4);
    tally_and_finish();
  end
endmodule : dpg_pulse_gen_tb_top
